// File: i2c_pkg.sv
package i2c_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h7E;
    localparam int BYTE_BITS = 8;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_RX = 3'b010,
        ST_RX_ACK = 3'b110,
        ST_TX = 3'b111,
        ST_TX_ACK = 3'b101,
        ST_IGNORE = 3'b100
    } slave_state_t;

    typedef struct packed
    {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : i2c_pkg

// File: line_sync.sv
`timescale 1ns/1ps
module line_sync
    import i2c_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // refuse a width that leaves nothing to synchronise
    if (WIDTH < 1)
    begin : g_width_check
        $error("line_sync width must be positive");
    end

    // two flip-flops; the first is read only by the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : line_sync

// File: i2c_slave_regs.sv
// Behaviour
// [RULE_01] a read opens with start, the device address and a write direction bit of zero.
// [RULE_02] the device acknowledges the address byte only when the seven address bits match its own.
// [RULE_03] the byte after an acknowledged write address is acknowledged and loaded as the register pointer.
// [RULE_04] a read continues with a repeated start and the device address with direction bit one.
// [RULE_05] on a matching read address the device acknowledges and sends the register under the pointer.
// [RULE_06] each byte the master acknowledges advances the pointer and the next register is sent.
// [RULE_07] the master ends a read with a not-acknowledge and stop; the device stops sending on it.
// [RULE_08] a write is address, pointer and data bytes, each acknowledged, to successive registers until stop.
// [RULE_09] the device answers only its own fixed seven-bit address.
// [RULE_10] a data line change while the clock is high mid transfer aborts the transaction.
// [RULE_11] bytes are eight bits, most significant first, each followed by an acknowledge slot.
// [RULE_12] on an address mismatch the data line stays released and the pointer is kept.
`timescale 1ns/1ps
module i2c_slave_regs
    import i2c_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = DEV_ADDR
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output reg_req_t reg_req,
    output logic reg_req_valid,
    output logic reg_rd_strobe,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_ptr,
    output logic busy
);
    logic [1:0] line_sync_out;
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    slave_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic ptr_loaded_reg;
    logic drive_low_reg;
    logic master_ack_reg;
    logic dir_read_reg;

    line_sync #(.WIDTH(2)) u_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({scl_in, sda_in}),
        .sync_out(line_sync_out)
    );

    assign scl_s = line_sync_out[1];
    assign sda_s = line_sync_out[0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // edge and condition detection on the sampled lines
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // main protocol sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= BIT_CNT_RESET;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            reg_ptr <= PTR_RESET;
            ptr_loaded_reg <= 1'b0;
            drive_low_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            dir_read_reg <= 1'b0;
            reg_req <= '0;
            reg_req_valid <= 1'b0;
            reg_rd_strobe <= 1'b0;
        end
        else
        begin
            reg_req_valid <= 1'b0;
            reg_rd_strobe <= 1'b0;
            if (start_det)
            begin
                // start or repeated start: fresh address phase
                state_reg <= ST_ADDR;
                bit_cnt_reg <= BIT_CNT_RESET;
                drive_low_reg <= 1'b0;
            end
            else if (stop_det)
            begin
                // stop, or a rising data change with clock high mid byte, ends everything; a falling one is taken as a start above
                state_reg <= ST_IDLE; // RULE_10
                drive_low_reg <= 1'b0;
            end
            else
            begin
                unique case (state_reg)
                    ST_IDLE, ST_IGNORE:
                    begin
                        drive_low_reg <= 1'b0; // RULE_12
                    end
                    ST_ADDR, ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg <= {shift_reg[6:0], sda_s}; // RULE_11
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_reg == 4'(BYTE_BITS))
                        begin
                            bit_cnt_reg <= BIT_CNT_RESET;
                            if (state_reg == ST_ADDR)
                            begin
                                if (shift_reg[7:1] == SLAVE_ADDR) // RULE_02 RULE_09
                                begin
                                    drive_low_reg <= 1'b1;
                                    dir_read_reg <= shift_reg[0];
                                    state_reg <= ST_ADDR_ACK;
                                    if (!shift_reg[0])
                                    begin
                                        ptr_loaded_reg <= 1'b0; // RULE_01
                                    end
                                end
                                else
                                begin
                                    state_reg <= ST_IGNORE; // RULE_12
                                end
                            end
                            else
                            begin
                                drive_low_reg <= 1'b1;
                                state_reg <= ST_RX_ACK;
                                if (!ptr_loaded_reg)
                                begin
                                    reg_ptr <= shift_reg; // RULE_03
                                    ptr_loaded_reg <= 1'b1;
                                end
                                else
                                begin
                                    reg_req.we <= 1'b1; // RULE_08
                                    reg_req.addr <= reg_ptr;
                                    reg_req.wdata <= shift_reg;
                                    reg_req_valid <= 1'b1;
                                    reg_ptr <= reg_ptr + 8'h01;
                                end
                            end
                        end
                    end
                    ST_ADDR_ACK, ST_RX_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (state_reg == ST_ADDR_ACK && dir_read_reg)
                            begin
                                tx_reg <= reg_rdata; // RULE_04 RULE_05
                                reg_rd_strobe <= 1'b1;
                                drive_low_reg <= !reg_rdata[7];
                                bit_cnt_reg <= 4'h1;
                                state_reg <= ST_TX;
                            end
                            else
                            begin
                                drive_low_reg <= 1'b0;
                                state_reg <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_reg == 4'(BYTE_BITS))
                            begin
                                drive_low_reg <= 1'b0;
                                bit_cnt_reg <= BIT_CNT_RESET;
                                state_reg <= ST_TX_ACK;
                            end
                            else
                            begin
                                drive_low_reg <= !tx_reg[3'(7 - bit_cnt_reg)]; // RULE_11
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    ST_TX_ACK:
                    begin
                        if (scl_rise)
                        begin
                            master_ack_reg <= !sda_s;
                            if (!sda_s)
                            begin
                                reg_ptr <= reg_ptr + 8'h01; // RULE_06
                            end
                        end
                        else if (scl_fall)
                        begin
                            if (master_ack_reg)
                            begin
                                tx_reg <= reg_rdata; // RULE_06
                                reg_rd_strobe <= 1'b1;
                                drive_low_reg <= !reg_rdata[7];
                                bit_cnt_reg <= 4'h1;
                                state_reg <= ST_TX;
                            end
                            else
                            begin
                                drive_low_reg <= 1'b0; // RULE_07
                                state_reg <= ST_IGNORE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // open-drain pin: output low, enable active low while pulling down
    assign sda_out = 1'b0;
    assign sda_oe_n = !drive_low_reg;
    assign busy = (state_reg != ST_IDLE);
endmodule : i2c_slave_regs

// File: i2c_slave_regs_assertions.sv
`timescale 1ns/1ps
module i2c_slave_regs_assertions
    import i2c_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire reg_req_t reg_req,
    input wire logic reg_req_valid,
    input wire logic reg_rd_strobe,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] reg_ptr,
    input wire logic busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence start_seen;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    sequence stop_seen;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    a_data_stable_high: assert property (scl_in [*4] |-> $stable(sda_oe_n)) else $error("sda moved, scl high");
    a_open_drain: assert property (sda_out == 1'b0) else $error("sda_out not low");
    a_start_busy: assert property (start_seen |-> ##[1:4] busy) else $error("start missed");
    a_stop_abort: assert property (stop_seen |-> ##[1:4] !busy) else $error("stop missed");
    a_idle_released: assert property (!busy |-> sda_oe_n) else $error("sda held when idle");
    a_ptr_kept: assert property (!busy && $past(!busy) |-> $stable(reg_ptr)) else $error("ptr moved idle");
    a_write_in_txn: assert property (reg_req_valid |-> busy && reg_req.we) else $error("stray write");
    a_write_bump: assert property (reg_req_valid |-> ##[0:2] reg_ptr == reg_req.addr + 8'h01)
        else $error("ptr not bumped");
    a_fetch_scl_low: assert property (reg_rd_strobe |-> busy && !scl_in) else $error("bad fetch");
endmodule : i2c_slave_regs_assertions
bind i2c_slave_regs i2c_slave_regs_assertions u_sva (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_req(reg_req), .reg_req_valid(reg_req_valid),
    .reg_rd_strobe(reg_rd_strobe), .reg_rdata(reg_rdata), .reg_ptr(reg_ptr), .busy(busy));

// File: i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model
    import i2c_pkg::*;
(
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // start or repeated start
    task automatic start_cond();
        sda_low = 1'b0;
        #20 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask : start_cond
    task automatic stop_cond();
        sda_low = 1'b1;
        #20 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask : stop_cond
    // msb first, ack slot only for a whole byte
    task automatic xfer(input logic [7:0] tx, input int nbits, input logic m_ack, output logic [7:0] rx,
        output logic s_ack);
        rx = 8'h00;
        s_ack = 1'b0;
        for (int i = 7; i >= 8 - nbits; i--)
        begin
            sda_low = ~tx[i];
            #20 scl = 1'b1;
            #20 rx[i] = sda;
            #20 scl = 1'b0;
            #20;
        end
        if (nbits == 8)
        begin
            sda_low = m_ack;
            #20 scl = 1'b1;
            #20 s_ack = ~sda;
            #20 scl = 1'b0;
            #20;
        end
    endtask : xfer
endmodule : i2c_master_model

// File: i2c_slave_regs_test.sv
`timescale 1ns/1ps
module i2c_slave_regs_test
    import i2c_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, m_low, sda_line, sda_out, sda_oe_n, reg_req_valid, reg_rd_strobe, busy, ack;
    reg_req_t reg_req;
    logic [7:0] reg_rdata, reg_ptr, rx, keep;
    logic [7:0] regs [256];
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_fetch = 0;
    always #5 clk = ~clk;
    // count register fetches made for transmit
    always @(posedge clk)
    begin
        if (reg_rd_strobe === 1'b1)
        begin
            n_fetch = n_fetch + 1;
        end
    end
    assign sda_line = ~(m_low | ~sda_oe_n);
    assign reg_rdata = regs[reg_ptr];
    i2c_slave_regs u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .reg_req(reg_req), .reg_req_valid(reg_req_valid), .reg_rd_strobe(reg_rd_strobe),
        .reg_rdata(reg_rdata), .reg_ptr(reg_ptr), .busy(busy));
    i2c_master_model u_master (.sda(sda_line), .scl(scl), .sda_low(m_low));
    // register bank behind the port
    always @(posedge clk)
    begin
        if (reg_req_valid === 1'b1)
        begin
            regs[reg_req.addr] <= reg_req.wdata;
        end
    end
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 8000)
        begin
            miscompares = miscompares + 1;
            conclude();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic conclude();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic open_ptr(input logic [7:0] ptr);
        u_master.start_cond();
        u_master.xfer({DEV_ADDR, 1'b0}, 8, 1'b0, rx, ack);
        chk("addr ack", 8'h01, {7'h00, ack});
        u_master.xfer(ptr, 8, 1'b0, rx, ack);
        chk("ptr ack", 8'h01, {7'h00, ack});
        chk("reg_ptr", ptr, reg_ptr);
    endtask : open_ptr
    task automatic t_write();
        open_ptr(8'hFF);
        u_master.xfer(8'hA5, 8, 1'b0, rx, ack);
        chk("data ack", 8'h01, {7'h00, ack});
        u_master.xfer(8'h3C, 8, 1'b0, rx, ack);
        chk("data ack", 8'h01, {7'h00, ack});
        u_master.stop_cond();
        chk("reg_ptr", 8'h01, reg_ptr);
        chk("write flag", 8'h01, {7'h00, reg_req.we});
        chk("reg FF", 8'hA5, regs[8'hFF]);
        chk("reg 00", 8'h3C, regs[8'h00]);
    endtask : t_write
    task automatic t_read();
        n_fetch = 0;
        open_ptr(8'hFF);
        u_master.start_cond();
        u_master.xfer({DEV_ADDR, 1'b1}, 8, 1'b0, rx, ack);
        chk("read addr ack", 8'h01, {7'h00, ack});
        u_master.xfer(8'hFF, 8, 1'b1, rx, ack);
        chk("read byte 0", 8'hA5, rx);
        u_master.xfer(8'hFF, 8, 1'b0, rx, ack);
        chk("read byte 1", 8'h3C, rx);
        chk("released", 8'h01, {7'h00, sda_line});
        chk("fetches", 8'h02, 8'(n_fetch));
        u_master.stop_cond();
        chk("busy", 8'h00, {7'h00, busy});
        chk("reg_ptr", 8'h00, reg_ptr);
    endtask : t_read
    task automatic t_mismatch();
        keep = reg_ptr;
        u_master.start_cond();
        u_master.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 8, 1'b0, rx, ack);
        chk("other addr ack", 8'h00, {7'h00, ack});
        u_master.xfer(8'h55, 8, 1'b0, rx, ack);
        chk("ignored ack", 8'h00, {7'h00, ack});
        u_master.stop_cond();
        chk("reg_ptr kept", keep, reg_ptr);
    endtask : t_mismatch
    task automatic t_abort();
        open_ptr(8'h40);
        u_master.xfer(8'h99, 4, 1'b0, rx, ack);
        u_master.stop_cond();
        chk("busy", 8'h00, {7'h00, busy});
        chk("reg 40", 8'h00, regs[8'h40]);
        open_ptr(8'h41);
        u_master.stop_cond();
    endtask : t_abort
    initial
    begin
        for (int i = 0; i < 256; i++)
            regs[i] = 8'h00;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_write();
        t_read();
        t_mismatch();
        t_abort();
        conclude();
    end
endmodule : i2c_slave_regs_test
